// ### design/mfr_fast_read.sv
`timescale 1ns/1ps
module mfr_fast_read #(
	parameter int BUF_DEPTH = mfr_pkg::BUF_BYTES
) (
	// System side
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic quadLinesEnable,
	input wire logic wpPinFunction,
	input wire logic readModeSelect,
	input wire logic bufWrEn,
	input wire logic [mfr_pkg::PTR_W-1:0] bufWrAddr,
	input wire logic [7:0] bufWrData,
	output logic pageAdvance,
	// Serial link
	input wire logic spiClk,
	input wire logic csN,
	input wire logic [3:0] ioIn,
	output logic [3:0] ioOut,
	output logic [3:0] ioOe
);
	function automatic logic opKnown(input logic [7:0] op);
		case (op)
			mfr_pkg::OP_DUAL_OUT, mfr_pkg::OP_DUAL_OUT_4B,
			mfr_pkg::OP_QUAD_OUT, mfr_pkg::OP_QUAD_OUT_4B,
			mfr_pkg::OP_DUAL_IO, mfr_pkg::OP_DUAL_IO_4B,
			mfr_pkg::OP_QUAD_IO, mfr_pkg::OP_QUAD_IO_4B: opKnown = 1'b1;
			default: opKnown = 1'b0;
		endcase
	endfunction

	function automatic logic opQuad(input logic [7:0] op);
		case (op)
			mfr_pkg::OP_QUAD_OUT, mfr_pkg::OP_QUAD_OUT_4B,
			mfr_pkg::OP_QUAD_IO, mfr_pkg::OP_QUAD_IO_4B: opQuad = 1'b1;
			default: opQuad = 1'b0;
		endcase
	endfunction

	function automatic logic opWide(input logic [7:0] op);
		case (op)
			mfr_pkg::OP_DUAL_OUT_4B, mfr_pkg::OP_QUAD_OUT_4B,
			mfr_pkg::OP_DUAL_IO_4B, mfr_pkg::OP_QUAD_IO_4B: opWide = 1'b1;
			default: opWide = 1'b0;
		endcase
	endfunction

	function automatic logic [2:0] addrLanes(input logic [7:0] op);
		case (op)
			mfr_pkg::OP_DUAL_IO, mfr_pkg::OP_DUAL_IO_4B: addrLanes = mfr_pkg::LANE_2;
			mfr_pkg::OP_QUAD_IO, mfr_pkg::OP_QUAD_IO_4B: addrLanes = mfr_pkg::LANE_4;
			default: addrLanes = mfr_pkg::LANE_1;
		endcase
	endfunction

	function automatic logic [5:0] addrTotal(input logic [7:0] op,
		input logic bufMode);
		if (opWide(op))
			addrTotal = mfr_pkg::AD_BITS_4B;
		else if (bufMode)
			addrTotal = mfr_pkg::AD_BITS_2B_BUF;
		else
			addrTotal = mfr_pkg::AD_BITS_2B_CONT;
	endfunction

	// Link side view of the static configuration
	logic [2:0] cfgSync;
	logic cfgBuf;
	logic cfgQe;
	logic cfgWp;

	mfr_sync #(.WIDTH(3)) uCfgSync (
		.clk(spiClk),
		.rst(1'b0),
		.din({wpPinFunction, quadLinesEnable, readModeSelect}),
		.dout(cfgSync)
	);

	assign cfgBuf = cfgSync[0];
	assign cfgQe = cfgSync[1];
	assign cfgWp = cfgSync[2];

	// Command and address capture, rising edge
	mfr_pkg::mfr_state_e state_r, state_nxt;
	logic [7:0] opSr_r, opSr_nxt;
	logic [2:0] bitCnt_r, bitCnt_nxt;
	logic [7:0] op_r, op_nxt;
	logic bufMode_r, bufMode_nxt;
	logic [15:0] colAddr_r, colAddr_nxt;
	logic [5:0] addrCnt_r, addrCnt_nxt;
	logic [2:0] lanes;

	always_comb
	begin
		state_nxt = state_r;
		opSr_nxt = opSr_r;
		bitCnt_nxt = bitCnt_r;
		op_nxt = op_r;
		bufMode_nxt = bufMode_r;
		colAddr_nxt = colAddr_r;
		addrCnt_nxt = addrCnt_r;
		lanes = addrLanes(op_r);
		unique case (state_r)
			mfr_pkg::ST_OPCODE:
			begin
				opSr_nxt = {opSr_r[6:0], ioIn[0]};
				bitCnt_nxt = 3'(bitCnt_r + 3'h1);
				if (bitCnt_r == mfr_pkg::OP_LAST_BIT)
				begin
					op_nxt = opSr_nxt;
					bufMode_nxt = cfgBuf;
					addrCnt_nxt = '0;
					if (!opKnown(opSr_nxt))
						state_nxt = mfr_pkg::ST_REJECT;
					else if (opQuad(opSr_nxt) && (!cfgQe || cfgWp))
						state_nxt = mfr_pkg::ST_REJECT;
					else
						state_nxt = mfr_pkg::ST_ADDR;
				end
			end
			mfr_pkg::ST_ADDR:
			begin
				if (addrCnt_r < 6'(mfr_pkg::COL_W))
				begin
					unique case (lanes)
						mfr_pkg::LANE_4: colAddr_nxt = {colAddr_r[11:0], ioIn};
						mfr_pkg::LANE_2: colAddr_nxt = {colAddr_r[13:0], ioIn[1:0]};
						default: colAddr_nxt = {colAddr_r[14:0], ioIn[0]};
					endcase
				end
				addrCnt_nxt = 6'(addrCnt_r + 6'(lanes));
				if (addrCnt_nxt == addrTotal(op_r, bufMode_r))
					state_nxt = mfr_pkg::ST_DATA;
			end
			mfr_pkg::ST_DATA,
			mfr_pkg::ST_REJECT: state_nxt = state_r;
		endcase
	end

	// Chip select high ends any instruction
	always_ff @(posedge spiClk or posedge csN)
	begin
		if (csN)
		begin
			state_r <= mfr_pkg::ST_OPCODE;
			opSr_r <= '0;
			bitCnt_r <= '0;
			op_r <= '0;
			bufMode_r <= 1'b0;
			colAddr_r <= '0;
			addrCnt_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			opSr_r <= opSr_nxt;
			bitCnt_r <= bitCnt_nxt;
			op_r <= op_nxt;
			bufMode_r <= bufMode_nxt;
			colAddr_r <= colAddr_nxt;
			addrCnt_r <= addrCnt_nxt;
		end
	end

	// Data shifting, falling edge
	logic started_r, started_nxt;
	logic done_r, done_nxt;
	logic [11:0] ptr_r, ptr_nxt;
	logic [3:0] rem_r, rem_nxt;
	logic [3:0] ioOut_r, ioOut_nxt;
	logic [3:0] ioOe_r, ioOe_nxt;
	logic [11:0] curPtr;
	logic [7:0] rdByte;
	logic [7:0] shifted;
	logic [3:0] remNow;
	logic [3:0] remLeft;
	logic lastSlice;

	mfr_page_buf #(.DEPTH(BUF_DEPTH)) uPageBuf (
		.wrClk(sys_clk),
		.wrEn(bufWrEn),
		.wrAddr(bufWrAddr),
		.wrData(bufWrData),
		.rdAddr(curPtr),
		.rdData(rdByte)
	);

	// Start point: column address or byte zero
	assign curPtr = started_r ? ptr_r
		: (bufMode_r ? colAddr_r[11:0] : '0);
	assign remNow = started_r ? rem_r : mfr_pkg::BYTE_BITS;
	assign shifted = 8'(rdByte << (mfr_pkg::BYTE_BITS - remNow));
	assign remLeft = 4'(remNow - (opQuad(op_r) ? 4'h4 : 4'h2));
	assign lastSlice = (remLeft == 4'h0);

	always_comb
	begin
		started_nxt = started_r;
		done_nxt = done_r;
		ptr_nxt = ptr_r;
		rem_nxt = rem_r;
		ioOut_nxt = ioOut_r;
		ioOe_nxt = mfr_pkg::OE_OFF;
		if (state_r == mfr_pkg::ST_DATA && !done_r)
		begin
			if (!started_r && bufMode_r && colAddr_r >= mfr_pkg::BUF_END_COL)
				done_nxt = 1'b1;
			else
			begin
				started_nxt = 1'b1;
				if (opQuad(op_r))
				begin
					ioOut_nxt = shifted[7:4];
					ioOe_nxt = mfr_pkg::OE_QUAD;
				end
				else
				begin
					ioOut_nxt = {2'b00, shifted[7:6]};
					ioOe_nxt = mfr_pkg::OE_DUAL;
				end
				rem_nxt = lastSlice ? mfr_pkg::BYTE_BITS : remLeft;
				ptr_nxt = curPtr;
				if (lastSlice)
				begin
					if (curPtr != mfr_pkg::BUF_LAST)
						ptr_nxt = 12'(curPtr + 12'h001);
					else if (bufMode_r)
						done_nxt = 1'b1;
					else
						ptr_nxt = '0;
				end
			end
		end
	end

	always_ff @(negedge spiClk or posedge csN)
	begin
		if (csN)
		begin
			started_r <= 1'b0;
			done_r <= 1'b0;
			ptr_r <= '0;
			rem_r <= mfr_pkg::BYTE_BITS;
			ioOut_r <= '0;
			ioOe_r <= mfr_pkg::OE_OFF;
		end
		else
		begin
			started_r <= started_nxt;
			done_r <= done_nxt;
			ptr_r <= ptr_nxt;
			rem_r <= rem_nxt;
			ioOut_r <= ioOut_nxt;
			ioOe_r <= ioOe_nxt;
		end
	end

	assign ioOut = ioOut_r;
	assign ioOe = ioOe_r;

	// Page roll event; survives chip select so no false edge is seen
	logic pageTgl_r, pageTgl_nxt;
	logic pageRoll;

	assign pageRoll = (state_r == mfr_pkg::ST_DATA) && !done_r && started_r
		&& lastSlice && !bufMode_r && (curPtr == mfr_pkg::BUF_LAST);

	always_comb
	begin
		pageTgl_nxt = pageRoll ? !pageTgl_r : pageTgl_r;
	end

	// Cleared straight from srst: link clock is idle during reset
	always_ff @(negedge spiClk or posedge srst)
	begin
		if (srst)
			pageTgl_r <= 1'b0;
		else
			pageTgl_r <= pageTgl_nxt;
	end

	// System side edge detect of the roll toggle
	logic pageTglSys;
	logic pageTglSeen_r, pageTglSeen_nxt;
	logic pageAdv_r, pageAdv_nxt;

	mfr_sync #(.WIDTH(1)) uPageSync (
		.clk(sys_clk),
		.rst(srst),
		.din(pageTgl_r),
		.dout(pageTglSys)
	);

	always_comb
	begin
		pageTglSeen_nxt = pageTglSys;
		pageAdv_nxt = pageTglSys ^ pageTglSeen_r;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			pageTglSeen_r <= 1'b0;
			pageAdv_r <= 1'b0;
		end
		else
		begin
			pageTglSeen_r <= pageTglSeen_nxt;
			pageAdv_r <= pageAdv_nxt;
		end
	end

	assign pageAdvance = pageAdv_r;

	chk_quad_gate: assert property (@(posedge spiClk) disable iff (csN)
		(state_r == mfr_pkg::ST_OPCODE && bitCnt_r == mfr_pkg::OP_LAST_BIT
		&& opQuad({opSr_r[6:0], ioIn[0]}) && !cfgQe)
		|=> state_r == mfr_pkg::ST_REJECT)
		else $error("quad read accepted without quad lines enable");

	chk_wp_disable: assert property (@(posedge spiClk) disable iff (csN)
		(state_r == mfr_pkg::ST_OPCODE && bitCnt_r == mfr_pkg::OP_LAST_BIT
		&& opQuad({opSr_r[6:0], ioIn[0]}) && cfgWp)
		|=> state_r == mfr_pkg::ST_REJECT)
		else $error("quad read accepted while write protect function set");

	chk_reject_hiz: assert property (@(negedge spiClk) disable iff (csN)
		state_r == mfr_pkg::ST_REJECT |-> ioOe_r == mfr_pkg::OE_OFF)
		else $error("lines driven after rejected opcode");

	chk_dual_lanes: assert property (@(negedge spiClk) disable iff (csN)
		(ioOe_r != mfr_pkg::OE_OFF && !opQuad(op_r))
		|-> ioOe_r == mfr_pkg::OE_DUAL && state_r == mfr_pkg::ST_DATA)
		else $error("dual read drives wrong lanes");

	chk_quad_lanes: assert property (@(negedge spiClk) disable iff (csN)
		(ioOe_r != mfr_pkg::OE_OFF && opQuad(op_r))
		|-> ioOe_r == mfr_pkg::OE_QUAD && cfgQe)
		else $error("quad read drives wrong lanes");

	chk_end_hiz: assert property (@(negedge spiClk) disable iff (csN)
		(done_r && $past(done_r)) |-> ioOe_r == mfr_pkg::OE_OFF)
		else $error("lines driven past end of buffer");

	chk_col_start: assert property (@(negedge spiClk) disable iff (csN)
		($rose(started_r) && bufMode_r) |-> ptr_r == colAddr_r[11:0])
		else $error("buffer read did not start at column address");

	chk_cont_start: assert property (@(negedge spiClk) disable iff (csN)
		($rose(started_r) && !bufMode_r) |-> ptr_r == 12'h000)
		else $error("continuous read did not start at byte zero");

	chk_addr_step: assert property (@(negedge spiClk) disable iff (csN)
		(started_r && !done_r && state_r == mfr_pkg::ST_DATA && lastSlice
		&& ptr_r != mfr_pkg::BUF_LAST) |=> ptr_r == 12'($past(ptr_r) + 12'h001))
		else $error("buffer address did not step after byte");

	chk_page_wrap: assert property (@(negedge spiClk) disable iff (csN)
		pageRoll |=> ptr_r == 12'h000 && !done_r && pageTgl_r != $past(pageTgl_r))
		else $error("continuous read did not roll into next page");
endmodule // mfr_fast_read

// ### design/mfr_pkg.sv
package mfr_pkg;
	// Page buffer geometry
	localparam int BUF_BYTES = 2112;
	localparam int PTR_W = 12;
	localparam int COL_W = 16;
	localparam logic [11:0] BUF_LAST = 12'h83F;
	localparam logic [15:0] BUF_END_COL = 16'h0840;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] OP_LAST_BIT = 3'h7;
	// Opcodes
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_OUT_4B = 8'h3C;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_QUAD_OUT_4B = 8'h6C;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_DUAL_IO_4B = 8'hBC;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_QUAD_IO_4B = 8'hEC;
	// Address plus dummy bits after the opcode
	localparam logic [5:0] AD_BITS_2B_BUF = 6'h18;
	localparam logic [5:0] AD_BITS_2B_CONT = 6'h20;
	localparam logic [5:0] AD_BITS_4B = 6'h28;
	// Lane widths and output enables
	localparam logic [2:0] LANE_1 = 3'h1;
	localparam logic [2:0] LANE_2 = 3'h2;
	localparam logic [2:0] LANE_4 = 3'h4;
	localparam logic [3:0] OE_DUAL = 4'h3;
	localparam logic [3:0] OE_QUAD = 4'hF;
	localparam logic [3:0] OE_OFF = 4'h0;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		ST_OPCODE,
		ST_ADDR,
		ST_DATA,
		ST_REJECT
	} mfr_state_e;
endpackage

// ### design/mfr_sync.sv
`timescale 1ns/1ps
module mfr_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = mfr_pkg::SYNC_STAGES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level in and out
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage_r [STAGES];
	logic [WIDTH-1:0] stage_nxt [STAGES];

	// First stage feeds only the next stage
	always_comb
	begin
		stage_nxt[0] = din;
		for (int i = 1; i < STAGES; i++)
			stage_nxt[i] = stage_r[i-1];
	end

	always_ff @(posedge clk)
	begin
		for (int i = 0; i < STAGES; i++)
			stage_r[i] <= rst ? '0 : stage_nxt[i];
	end

	assign dout = stage_r[STAGES-1];
endmodule // mfr_sync

// ### design/mfr_page_buf.sv
`timescale 1ns/1ps
module mfr_page_buf #(
	parameter int DEPTH = mfr_pkg::BUF_BYTES,
	parameter int AW = mfr_pkg::PTR_W
) (
	// Load side
	input wire logic wrClk,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [7:0] wrData,
	// Read side, combinational
	input wire logic [AW-1:0] rdAddr,
	output logic [7:0] rdData
);
	logic [7:0] mem [DEPTH];

	// Out of range writes dropped rather than aliased
	always_ff @(posedge wrClk)
	begin
		if (wrEn && (int'(wrAddr) < DEPTH))
			mem[wrAddr] <= wrData;
	end

	assign rdData = (int'(rdAddr) < DEPTH) ? mem[rdAddr] : 8'h00;
endmodule // mfr_page_buf

// ### tb/mfr_host.sv
`timescale 1ns/1ps
module mfr_host (
	// Link pins
	output logic spiClk,
	output logic csN,
	output logic [3:0] ioIn,
	input wire logic [3:0] ioOut,
	input wire logic [3:0] ioOe
);
	logic [3:0] hostDrv;
	logic [3:0] slc[$];
	logic [3:0] oes[$];
	// Lanes the device leaves alone show a toggling host pattern
	assign ioIn = (ioOe & ioOut) | (~ioOe & hostDrv);
	initial
	begin
		spiClk = 1'b0;
		hostDrv = 4'hA;
		// Late rise so the link side sees a real reset edge
		#1;
		csN = 1'b1;
	end
	// Change after falling edge, capture just before rising edge
	task automatic tick(input logic [3:0] d, input bit cap);
		hostDrv = d;
		#15;
		if (cap)
		begin
			slc.push_back(ioIn);
			oes.push_back(ioOe);
		end
		spiClk = 1'b1;
		#15;
		spiClk = 1'b0;
		#1;
	endtask
	// Clock stands still outside frames
	task automatic frame(input logic [7:0] op, input logic [15:0] col,
		input int adBits, input int lanes, input int nData);
		logic [39:0] ad;
		logic [3:0] d;
		slc.delete();
		oes.delete();
		ad = {col, 24'h000000};
		csN = 1'b0;
		#7;
		for (int i = 7; i >= 0; i--)
			tick({~hostDrv[3:1], op[i]}, 1'b0);
		for (int k = 0; k < adBits / lanes; k++)
		begin
			d = ~hostDrv;
			for (int j = 0; j < lanes; j++)
				d[lanes - 1 - j] = ad[39 - k * lanes - j];
			tick(d, 1'b0);
		end
		for (int n = 0; n < nData; n++)
			tick(~hostDrv, 1'b1);
		csN = 1'b1;
		#20;
	endtask
endmodule // mfr_host

// ### tb/multi_io_buffer_fast_read_tb.sv
`timescale 1ns/1ps
module multi_io_buffer_fast_read_tb;
	logic sys_clk, srst, quadLinesEnable, wpPinFunction, readModeSelect;
	logic bufWrEn, pageAdvance, spiClk, csN;
	logic [11:0] bufWrAddr;
	logic [7:0] bufWrData;
	logic [3:0] ioIn, ioOut, ioOe;
	int fails = 0;
	int checkCount = 0;
	int pulses = 0;

	mfr_fast_read #(.BUF_DEPTH(2112)) dut (.sys_clk(sys_clk), .srst(srst),
		.quadLinesEnable(quadLinesEnable), .wpPinFunction(wpPinFunction),
		.readModeSelect(readModeSelect), .bufWrEn(bufWrEn),
		.bufWrAddr(bufWrAddr), .bufWrData(bufWrData),
		.pageAdvance(pageAdvance), .spiClk(spiClk), .csN(csN),
		.ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
	mfr_host host (.spiClk(spiClk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
		.ioOe(ioOe));

	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (pageAdvance === 1'b1)
			pulses++;

	task automatic step();
		@(posedge sys_clk);
		#5;
	endtask
	function automatic logic [7:0] pat(input int i);
		pat = 8'(i * 37 + (i >> 8) + 5);
	endfunction
	function automatic logic [7:0] byteAt(input int k, input bit quad);
		if (quad)
			byteAt = {host.slc[2 * k], host.slc[2 * k + 1]};
		else
			byteAt = {host.slc[4 * k][1:0], host.slc[4 * k + 1][1:0],
				host.slc[4 * k + 2][1:0], host.slc[4 * k + 3][1:0]};
	endfunction
	function automatic logic [3:0] oeFrom(input int a);
		oeFrom = 4'h0;
		for (int i = a; i < host.oes.size(); i++)
			oeFrom = oeFrom | host.oes[i];
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Every opcode in buffer mode, two bytes from a column
	task automatic t_ops();
		logic [7:0] ops[8] = '{8'h3B, 8'h3C, 8'h6B, 8'h6C,
			8'hBB, 8'hBC, 8'hEB, 8'hEC};
		bit quad;
		int ln, col;
		for (int i = 0; i < 8; i++)
		begin
			quad = (i == 2 || i == 3 || i >= 6);
			ln = (i < 4) ? 1 : ((i < 6) ? 2 : 4);
			col = 100 + i * 3;
			host.frame(ops[i], 16'(col), ops[i][0] ? 24 : 40, ln,
				quad ? 4 : 8);
			chk(byteAt(0, quad), pat(col));
			chk(byteAt(1, quad), pat(col + 1));
			chk({4'h0, host.oes[0]}, quad ? 8'h0F : 8'h03);
		end
	endtask
	// Quad opcodes refused without enable or with write-protect function
	task automatic t_refuse();
		logic [7:0] ops[4] = '{8'h6B, 8'h6C, 8'hEB, 8'hEC};
		for (int c = 0; c < 2; c++)
		begin
			quadLinesEnable = c[0];
			wpPinFunction = c[0];
			step();
			for (int i = 0; i < 4; i++)
			begin
				host.frame(ops[i], 16'h0010, ops[i][0] ? 24 : 40,
					(i < 2) ? 1 : 4, 6);
				chk({4'h0, oeFrom(0)}, 8'h00);
			end
		end
		quadLinesEnable = 1'b1;
		wpPinFunction = 1'b0;
		step();
	endtask
	// Last two buffer bytes then released lines
	task automatic t_bufend();
		host.frame(8'hEB, 16'd2110, 24, 4, 8);
		chk(byteAt(0, 1'b1), pat(2110));
		chk(byteAt(1, 1'b1), pat(2111));
		chk({4'h0, oeFrom(4)}, 8'h00);
		host.frame(8'h3B, 16'd2112, 24, 1, 4);
		chk({4'h0, oeFrom(0)}, 8'h00);
		host.frame(8'h0B, 16'h0010, 24, 1, 4);
		chk({4'h0, oeFrom(0)}, 8'h00);
	endtask
	// Continuous mode from byte zero across the page end
	task automatic t_cont();
		readModeSelect = 1'b0;
		step();
		pulses = 0;
		host.frame(8'h6B, 16'h0123, 32, 1, 2 * 2113);
		repeat (10) step();
		chk(byteAt(0, 1'b1), pat(0));
		chk(byteAt(5, 1'b1), pat(5));
		chk(byteAt(2111, 1'b1), pat(2111));
		chk(byteAt(2112, 1'b1), pat(0));
		chk(8'(pulses), 8'h01);
		readModeSelect = 1'b1;
		step();
	endtask

	initial
	begin
		// Late rise so the link side toggle sees a real reset edge
		#1;
		srst = 1'b1;
		quadLinesEnable = 1'b1;
		wpPinFunction = 1'b0;
		readModeSelect = 1'b1;
		bufWrEn = 1'b0;
		bufWrAddr = 12'h000;
		bufWrData = 8'h00;
		repeat (20) step();
		srst = 1'b0;
		step();
		chk({7'h00, pageAdvance}, 8'h00);
		chk({4'h0, ioOe}, 8'h00);
		for (int i = 0; i < 2112; i++)
		begin
			bufWrEn = 1'b1;
			bufWrAddr = 12'(i);
			bufWrData = pat(i);
			step();
		end
		bufWrEn = 1'b0;
		step();
		t_ops();
		t_refuse();
		t_bufend();
		t_cont();
		finish_test();
	end
	// Expected run is about 0.4 ms
	initial
	begin
		#2ms;
		fails++;
		finish_test();
	end
endmodule // multi_io_buffer_fast_read_tb
